// ### core/vctm_map.sv
// Vector fetch, short call target forming and data space decode
`timescale 1ns/1ps
`include "vctm_cfg.svh"

// Overview of operation
// - Reset causes and NMI fetch from fixed vectors 0000-0008
// - Interrupt sources use fixed vectors 000A-0072
// - Vector word low byte even, high odd
// - Indexed call table 004A-0069, sixteen words
// - Indexed call pushes return, stack minus two
// - Large mode: also save segment, minus four
// - Indexed call operand equals table address
// - Area call reaches 1000-17FF every segment
// - Area call pushes, minus two, 11-bit target
// - Area call keeps code segment unchanged
// - Data space is 64KB, separate from program
// - Data 0000-00FF decodes peripheral registers
// - Data 0100-01FF decodes reserved
// - Constant page: pointer set, short bit areas
// - ROM window 1000-FFFF inside external data
// - Small RAM variant: RAM to 05FF
// - Unused table behaves as plain program memory
// - Vector taken clears code segment register
// - Memory size control bit 1 selects large mode
// - Constant page decoded at 0200-02FF
module vctm_map (
  input  wire logic                          CLK,
  input  wire logic                          SRST,
  input  wire logic                          EXTERNAL_CLEAR_PIN,
  input  wire logic                          BREAK_OPCODE,
  input  wire logic                          WATCHDOG_OVF,
  input  wire logic                          OPCODE_TRAP,
  input  wire logic                          NMI_REQ,
  input  wire logic [`VCTM_NUM_IRQ-1:0]      IRQ_REQ,
  input  wire logic                          VECTORED_SHORT_CALL,
  input  wire logic [7:0]                    CALL_OPERAND,
  input  wire logic                          AREA_SHORT_CALL,
  input  wire logic [10:0]                   AREA_FIELD,
  input  wire logic [15:0]                   NEXT_PC,
  input  wire logic                          CUR_SEGMENT,
  input  wire logic [15:0]                   SYSTEM_STACK_POINTER,
  input  wire logic [7:0]                    MEMORY_SIZE_CTRL,
  input  wire logic                          SMALL_RAM_VARIANT,
  input  wire logic [7:0]                    PROG_RDATA,
  input  wire logic                          PROG_RVALID,
  input  wire logic [15:0]                   DATA_ADDR,
  output logic                               BUSY,
  output logic                               PROG_REQ,
  output logic [15:0]                        PROG_ADDR,
  output logic                               PC_LOAD,
  output logic [15:0]                        PC_VALUE,
  output logic                               SEGMENT_LOAD,
  output logic                               SEGMENT_VALUE,
  output logic                               PUSH_VALID,
  output logic [15:0]                        PUSH_PC,
  output logic                               PUSH_SEGMENT_EN,
  output logic                               PUSH_SEGMENT,
  output logic [15:0]                        NEXT_STACK_POINTER,
  output logic                               FAR_RETURN_REQUIRED,
  output logic [2:0]                         DATA_REGION,
  output logic                               DATA_POINTER_SET,
  output logic                               DATA_SHORT_BIT,
  output logic                               DATA_ROM_WINDOW
);

  vctm_pkg::vctm_state_t state;
  vctm_pkg::vctm_state_t next_state;
  logic [15:0] fetch_addr;
  logic [7:0]  low_byte;
  logic        is_vector;
  logic        is_call;
  logic [15:0] ret_pc;
  logic        ret_seg;

  // Large program space mode from the memory size control bit
  wire large_program_space_bit = MEMORY_SIZE_CTRL[`VCTM_LARGE_BIT_POS];

  // Interrupt vector per source: 000A, then 001A upward in table order
  wire [15:0] irq_vec [0:`VCTM_NUM_IRQ-1];
  // One word per source, lowest index first; words sit in 000A-0049 and 006A-0073
  localparam logic [15:0] IRQ_TBL [0:`VCTM_NUM_IRQ-1] = '{
    16'h000a,
    16'h001a,
    16'h001c,
    16'h001e,
    16'h0020,
    16'h0022,
    16'h0024,
    16'h0026,
    16'h002a,
    16'h002c,
    16'h002e,
    16'h0030,
    16'h0036,
    16'h0038,
    16'h003a,
    16'h003e,
    16'h0042,
    16'h0044,
    16'h006a,
    16'h006c,
    16'h006e,
    16'h0070,
    16'h0072
  };
  wire [`VCTM_NUM_IRQ-1:0] irq_sel;
  genvar gi;
  generate
    for (gi = 0; gi < `VCTM_NUM_IRQ; gi++) begin : g_irq
      // Lowest numbered pending source wins
      assign irq_vec[gi] = IRQ_TBL[gi];
      if (gi == 0) begin : g_first
        assign irq_sel[gi] = IRQ_REQ[gi];
      end else begin : g_rest
        assign irq_sel[gi] = IRQ_REQ[gi] & ~|IRQ_REQ[gi-1:0];
      end
    end
  endgenerate

  logic [15:0] irq_addr;
  // Select the vector of the winning interrupt source
  always_comb begin
    irq_addr = `VCTM_VEC_EXT_INT0;
    for (int i = `VCTM_NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_sel[i]) begin
        irq_addr = irq_vec[i];
      end
    end
  end

  // Event priority: reset causes outrank everything else
  wire any_reset = EXTERNAL_CLEAR_PIN | BREAK_OPCODE | WATCHDOG_OVF | OPCODE_TRAP;
  wire [15:0] reset_addr = EXTERNAL_CLEAR_PIN ? `VCTM_VEC_CLEAR_PIN :
                           BREAK_OPCODE       ? `VCTM_VEC_BREAK :
                           WATCHDOG_OVF       ? `VCTM_VEC_WATCHDOG : `VCTM_VEC_OPTRAP;

  // Then the non-maskable interrupt, then the maskable sources
  wire vec_event = any_reset | NMI_REQ | (|IRQ_REQ);
  wire [15:0] vec_addr = any_reset ? reset_addr : NMI_REQ ? `VCTM_VEC_NMI : irq_addr;

  // Operand is the table address; only even 4A..68 is a valid call slot
  wire call_even  = (CALL_OPERAND[0] == 1'b0);
  wire call_above = ({8'h00, CALL_OPERAND} >= `VCTM_CALL_TBL_START);
  wire call_below = (CALL_OPERAND <= `VCTM_CALL_OP_LAST);
  wire call_ok    = call_even & call_above & call_below;

  // Calls are taken only when no vector event is pending
  wire take_vcall = ~vec_event & VECTORED_SHORT_CALL & call_ok;
  wire take_acall = ~vec_event & ~VECTORED_SHORT_CALL & AREA_SHORT_CALL;
  wire [15:0] area_target = `VCTM_AREA_BASE | {5'h00, AREA_FIELD};
  wire [15:0] stack_step = large_program_space_bit ? `VCTM_STACK_FAR : `VCTM_STACK_NEAR;

  // Sequencer state update
  always_comb begin
    next_state = state;
    unique case (state)
      vctm_pkg::VCTM_IDLE: begin
        if (vec_event | take_vcall) begin
          next_state = vctm_pkg::VCTM_LOW;
        end else if (take_acall) begin
          next_state = vctm_pkg::VCTM_PUSH;
        end
      end
      vctm_pkg::VCTM_LOW: begin
        if (PROG_RVALID) begin
          next_state = vctm_pkg::VCTM_HIGH;
        end
      end
      vctm_pkg::VCTM_HIGH: begin
        if (PROG_RVALID) begin
          next_state = vctm_pkg::VCTM_LOAD;
        end
      end
      vctm_pkg::VCTM_LOAD: next_state = vctm_pkg::VCTM_IDLE;
      vctm_pkg::VCTM_PUSH: next_state = vctm_pkg::VCTM_IDLE;
      default:             next_state = vctm_pkg::VCTM_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= vctm_pkg::VCTM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request data captured while idle; the stack pointer and memory size control are read as the table read ends, but area calls read the stack pointer while idle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fetch_addr <= 16'h0000;
      is_vector  <= 1'b0;
      is_call    <= 1'b0;
      ret_pc     <= 16'h0000;
      ret_seg    <= 1'b0;
    end else if (state == vctm_pkg::VCTM_IDLE) begin
      fetch_addr <= vec_event ? vec_addr : {8'h00, CALL_OPERAND};
      is_vector  <= vec_event;
      is_call    <= take_vcall;
      ret_pc     <= NEXT_PC;
      ret_seg    <= CUR_SEGMENT;
    end
  end

  // Low byte of the table word, held until the high byte arrives
  always_ff @(posedge CLK) begin
    if (SRST) begin
      low_byte <= 8'h00;
    end else if (state == vctm_pkg::VCTM_LOW && PROG_RVALID) begin
      low_byte <= PROG_RDATA;
    end
  end

  // Table read finished or area call taken in this cycle
  wire table_done = (state == vctm_pkg::VCTM_HIGH) && PROG_RVALID;
  wire acall_now  = (state == vctm_pkg::VCTM_IDLE) && take_acall;
  wire vcall_done = table_done && is_call;

  // Program counter load pulse and target
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PC_LOAD  <= 1'b0;
      PC_VALUE <= 16'h0000;
    end else begin
      PC_LOAD <= table_done | acall_now;
      if (table_done) begin
        PC_VALUE <= {PROG_RDATA, low_byte};
      end else if (acall_now) begin
        PC_VALUE <= area_target;
      end
    end
  end

  // Segment cleared by vectors and large mode indexed calls; area calls leave it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SEGMENT_LOAD  <= 1'b0;
      SEGMENT_VALUE <= 1'b0;
    end else begin
      SEGMENT_LOAD  <= table_done & (is_vector | large_program_space_bit);
      SEGMENT_VALUE <= `VCTM_SEG_ZERO;
    end
  end

  // Return address push, with the segment too for indexed calls in large mode
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PUSH_VALID      <= 1'b0;
      PUSH_PC         <= 16'h0000;
      PUSH_SEGMENT_EN <= 1'b0;
      PUSH_SEGMENT    <= 1'b0;
    end else begin
      PUSH_VALID      <= vcall_done | acall_now;
      PUSH_SEGMENT_EN <= vcall_done & large_program_space_bit;
      if (vcall_done) begin
        PUSH_PC      <= ret_pc;
        PUSH_SEGMENT <= ret_seg;
      end else if (acall_now) begin
        PUSH_PC <= NEXT_PC;
      end
    end
  end

  // Stack pointer after the push: two bytes, or four with the segment
  always_ff @(posedge CLK) begin
    if (SRST) begin
      NEXT_STACK_POINTER <= 16'h0000;
    end else if (vcall_done) begin
      NEXT_STACK_POINTER <= SYSTEM_STACK_POINTER - stack_step;
    end else if (acall_now) begin
      NEXT_STACK_POINTER <= SYSTEM_STACK_POINTER - `VCTM_STACK_NEAR;
    end
  end

  // Program memory read handshake
  assign BUSY      = (state != vctm_pkg::VCTM_IDLE);
  assign PROG_REQ  = (state == vctm_pkg::VCTM_LOW) | (state == vctm_pkg::VCTM_HIGH);
  assign PROG_ADDR = (state == vctm_pkg::VCTM_HIGH) ? (fetch_addr | 16'h0001) : fetch_addr;
  assign FAR_RETURN_REQUIRED = large_program_space_bit;

  // Data space decode over a 16-bit address
  wire [15:0] ram_end = SMALL_RAM_VARIANT ? `VCTM_RAM_END_SMALL : `VCTM_RAM_END_FULL;
  wire d_periph = DATA_ADDR <= `VCTM_PERIPH_END;
  wire d_rsvd   = (DATA_ADDR >= `VCTM_RSVD_START) && (DATA_ADDR <= `VCTM_RSVD_END);
  wire d_const  = (DATA_ADDR >= `VCTM_CONST_START) && (DATA_ADDR <= `VCTM_CONST_END);
  wire d_ram    = (DATA_ADDR >= `VCTM_RAM_START) && (DATA_ADDR <= ram_end);
  assign DATA_REGION = d_periph ? 3'(vctm_pkg::VCTM_DR_PERIPH) :
                       d_rsvd   ? 3'(vctm_pkg::VCTM_DR_RESERVED) :
                       d_const  ? 3'(vctm_pkg::VCTM_DR_CONST) :
                       d_ram    ? 3'(vctm_pkg::VCTM_DR_RAM) : 3'(vctm_pkg::VCTM_DR_EXTERNAL);
  assign DATA_POINTER_SET = (DATA_ADDR >= `VCTM_CONST_START) && (DATA_ADDR <= `VCTM_PTR_SET_END);
  assign DATA_SHORT_BIT   = (DATA_ADDR >= `VCTM_SHORT_BIT_START) && (DATA_ADDR <= `VCTM_CONST_END);
  assign DATA_ROM_WINDOW  = (DATA_ADDR >= `VCTM_WINDOW_START) && ~d_ram;

endmodule

// ### core/vctm_cfg.svh
// Address map, vector and stack constants for the vector and call target map
`ifndef VCTM_CFG_SVH
`define VCTM_CFG_SVH
`define VCTM_VEC_CLEAR_PIN   16'h0000
`define VCTM_VEC_BREAK       16'h0002
`define VCTM_VEC_WATCHDOG    16'h0004
`define VCTM_VEC_OPTRAP      16'h0006
`define VCTM_VEC_NMI         16'h0008
`define VCTM_VEC_EXT_INT0    16'h000a
`define VCTM_VEC_TIMER0      16'h001a
`define VCTM_VEC_TIMER9      16'h0072
`define VCTM_VEC_LO_END      16'h0049
`define VCTM_VEC_HI_START    16'h006a
`define VCTM_VEC_HI_END      16'h0073
`define VCTM_CALL_TBL_START  16'h004a
`define VCTM_CALL_TBL_END    16'h0069
`define VCTM_CALL_OP_LAST    8'h68
`define VCTM_AREA_BASE       16'h1000
`define VCTM_AREA_END        16'h17ff
`define VCTM_STACK_NEAR      16'h0002
`define VCTM_STACK_FAR       16'h0004
`define VCTM_LARGE_BIT_POS   1
`define VCTM_SEG_ZERO        1'b0
`define VCTM_PERIPH_END      16'h00ff
`define VCTM_RSVD_START      16'h0100
`define VCTM_RSVD_END        16'h01ff
`define VCTM_CONST_START     16'h0200
`define VCTM_PTR_SET_END     16'h023f
`define VCTM_SHORT_BIT_START 16'h02c0
`define VCTM_CONST_END       16'h02ff
`define VCTM_RAM_START       16'h0200
`define VCTM_RAM_END_SMALL   16'h05ff
`define VCTM_RAM_END_FULL    16'h09ff
`define VCTM_WINDOW_START    16'h1000
`define VCTM_NUM_IRQ         23
`endif

// ### core/vctm_pkg.sv
// Types for the vector and call target map
package vctm_pkg;
  typedef enum logic [2:0] {
    VCTM_IDLE  = 3'b000,
    VCTM_LOW   = 3'b001,
    VCTM_HIGH  = 3'b010,
    VCTM_LOAD  = 3'b011,
    VCTM_PUSH  = 3'b100
  } vctm_state_t;
  typedef enum logic [2:0] {
    VCTM_DR_PERIPH   = 3'b000,
    VCTM_DR_RESERVED = 3'b001,
    VCTM_DR_CONST    = 3'b010,
    VCTM_DR_RAM      = 3'b011,
    VCTM_DR_EXTERNAL = 3'b100
  } vctm_region_t;
endpackage

// ### verification/vctm_map_checker.sv
// Concurrent checks on the ports of the vector and call target map
`timescale 1ns/1ps
module vctm_map_checker (
  input wire logic        CLK, SRST, EXTERNAL_CLEAR_PIN, PROG_RVALID, BUSY, PROG_REQ, PC_LOAD,
  input wire logic        SEGMENT_LOAD, SEGMENT_VALUE, PUSH_VALID, PUSH_SEGMENT_EN, FAR_RETURN_REQUIRED,
  input wire logic [7:0]  MEMORY_SIZE_CTRL,
  input wire logic [15:0] SYSTEM_STACK_POINTER, DATA_ADDR, PROG_ADDR, NEXT_STACK_POINTER,
  input wire logic [2:0]  DATA_REGION
);
  // All checks run on the core clock and rest during reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  clear_vec_a: assert property (!BUSY && EXTERNAL_CLEAR_PIN |=> PROG_REQ && PROG_ADDR == 16'h0000)
    else $error("clear pin vector not fetched");
  even_first_a: assert property ($rose(PROG_REQ) |-> !PROG_ADDR[0])
    else $error("first table read not even");
  odd_next_a: assert property (PROG_REQ && PROG_RVALID && !PROG_ADDR[0] |=> PROG_ADDR == $past(PROG_ADDR) + 16'h0001)
    else $error("second table read not odd");
  load_after_a: assert property (PROG_REQ && PROG_RVALID && PROG_ADDR[0] |=> PC_LOAD)
    else $error("counter not loaded after high byte");
  seg_zero_a: assert property (SEGMENT_LOAD |-> !SEGMENT_VALUE)
    else $error("segment load not zero");
  stack_step_a: assert property (PUSH_VALID |-> NEXT_STACK_POINTER ==
    $past(SYSTEM_STACK_POINTER) - (PUSH_SEGMENT_EN ? 16'h0004 : 16'h0002)) else $error("stack step wrong");
  far_ret_a: assert property (FAR_RETURN_REQUIRED == MEMORY_SIZE_CTRL[1])
    else $error("far return flag wrong");
  periph_area_a: assert property (DATA_ADDR[15:8] == 8'h00 |-> DATA_REGION == 3'h0)
    else $error("peripheral area decode wrong");
endmodule
bind vctm_map vctm_map_checker u_vctm_map_checker (.CLK, .SRST, .EXTERNAL_CLEAR_PIN, .PROG_RVALID, .BUSY,
  .PROG_REQ, .PC_LOAD, .SEGMENT_LOAD, .SEGMENT_VALUE, .PUSH_VALID, .PUSH_SEGMENT_EN, .FAR_RETURN_REQUIRED,
  .MEMORY_SIZE_CTRL, .SYSTEM_STACK_POINTER, .DATA_ADDR, .PROG_ADDR, .NEXT_STACK_POINTER, .DATA_REGION);

// ### verification/vctm_prog_model.sv
// Program memory model that answers byte reads promptly or slowly
`timescale 1ns/1ps
module vctm_prog_model (
  input  wire logic        CLK, SLOW, PROG_REQ,
  input  wire logic [15:0] PROG_ADDR,
  output logic [7:0]       PROG_RDATA,
  output logic             PROG_RVALID
);
  logic tog = 1'b0;
  // Slow mode answers only on every other cycle
  always @(posedge CLK) tog <= ~tog;
  // Byte follows its address; between answers the data lines toggle
  assign PROG_RVALID = PROG_REQ && (!SLOW || tog);
  assign PROG_RDATA  = PROG_RVALID ? (PROG_ADDR[7:0] ^ 8'h3c) : {8{tog}};
endmodule

// ### verification/vector_and_call_target_map_tb.sv
// Self-checking bench for the vector and call target map
`timescale 1ns/1ps
`include "vctm_cfg.svh"
module vector_and_call_target_map_tb;
  logic        CLK = 1'b0, SRST = 1'b1, SLOW = 1'b0, CUR_SEGMENT = 1'b1, SMALL_RAM_VARIANT = 1'b0;
  logic        EXTERNAL_CLEAR_PIN = 1'b0, BREAK_OPCODE = 1'b0, WATCHDOG_OVF = 1'b0, OPCODE_TRAP = 1'b0;
  logic        NMI_REQ = 1'b0, VECTORED_SHORT_CALL = 1'b0, AREA_SHORT_CALL = 1'b0;
  logic [`VCTM_NUM_IRQ-1:0] IRQ_REQ = '0;
  logic [7:0]  CALL_OPERAND = 8'h00, MEMORY_SIZE_CTRL = 8'h00, PROG_RDATA;
  logic [10:0] AREA_FIELD = 11'h000;
  logic [15:0] NEXT_PC = 16'h0000, SYSTEM_STACK_POINTER = 16'h0400, DATA_ADDR = 16'h0000;
  logic [15:0] PROG_ADDR, PC_VALUE, PUSH_PC, NEXT_STACK_POINTER;
  logic        BUSY, PROG_REQ, PROG_RVALID, PC_LOAD, SEGMENT_LOAD, SEGMENT_VALUE, PUSH_VALID, PUSH_SEGMENT_EN;
  logic        PUSH_SEGMENT, FAR_RETURN_REQUIRED, DATA_POINTER_SET, DATA_SHORT_BIT, DATA_ROM_WINDOW;
  logic [2:0]  DATA_REGION;
  int          n_fail = 0, num_checks = 0;
  vctm_map u_vctm_map (.CLK, .SRST, .EXTERNAL_CLEAR_PIN, .BREAK_OPCODE, .WATCHDOG_OVF, .OPCODE_TRAP, .NMI_REQ,
    .IRQ_REQ, .VECTORED_SHORT_CALL, .CALL_OPERAND, .AREA_SHORT_CALL, .AREA_FIELD, .NEXT_PC, .CUR_SEGMENT,
    .SYSTEM_STACK_POINTER, .MEMORY_SIZE_CTRL, .SMALL_RAM_VARIANT, .PROG_RDATA, .PROG_RVALID, .DATA_ADDR,
    .BUSY, .PROG_REQ, .PROG_ADDR, .PC_LOAD, .PC_VALUE, .SEGMENT_LOAD, .SEGMENT_VALUE, .PUSH_VALID, .PUSH_PC,
    .PUSH_SEGMENT_EN, .PUSH_SEGMENT, .NEXT_STACK_POINTER, .FAR_RETURN_REQUIRED, .DATA_REGION,
    .DATA_POINTER_SET, .DATA_SHORT_BIT, .DATA_ROM_WINDOW);
  vctm_prog_model u_vctm_prog_model (.CLK, .SLOW, .PROG_REQ, .PROG_ADDR, .PROG_RDATA, .PROG_RVALID);
  always #5 CLK = ~CLK;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Word the model holds at an even table address, low byte first
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return {a[7:0] ^ 8'h3d, a[7:0] ^ 8'h3c};
  endfunction
  // Holds the raised request over one taking edge, then waits for the load pulse
  task automatic issue;
    int n;
    for (n = 0; n < 30 && BUSY !== 1'b0; n++) @(negedge CLK);
    @(negedge CLK);
    {EXTERNAL_CLEAR_PIN, BREAK_OPCODE, WATCHDOG_OVF, OPCODE_TRAP, NMI_REQ} = 5'h00;
    IRQ_REQ = '0;
    VECTORED_SHORT_CALL = 1'b0;
    AREA_SHORT_CALL = 1'b0;
    for (n = 0; n < 30 && PC_LOAD !== 1'b1; n++) @(negedge CLK);
    chk("pc_load", 16'h0001, {15'h0000, PC_LOAD});
  endtask
  task automatic t_vectors;
    logic [15:0] va [8] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h001a, 16'h0072};
    for (int i = 0; i < 8; i++) begin
      SLOW = i[0];
      {EXTERNAL_CLEAR_PIN, BREAK_OPCODE, WATCHDOG_OVF, OPCODE_TRAP, NMI_REQ} = 5'h10 >> i;
      IRQ_REQ = (i == 5) ? 23'h000001 : (i == 6) ? 23'h000002 : (i == 7) ? 23'h400000 : 23'h000000;
      issue;
      chk("vector_pc", word_at(va[i]), PC_VALUE);
      chk("vector_seg", 16'h0003, {14'h0000, SEGMENT_LOAD, ~SEGMENT_VALUE});
    end
    $display("done t_vectors");
  endtask
  task automatic t_vcall;
    logic [7:0] op;
    for (int m = 0; m < 4; m++) begin
      op = m[0] ? 8'h68 : 8'h4a;
      MEMORY_SIZE_CTRL = {6'h00, m[1], 1'b0};
      CALL_OPERAND = op;
      NEXT_PC = {8'h12, op};
      SLOW = m[0];
      VECTORED_SHORT_CALL = 1'b1;
      issue;
      chk("call_pc", word_at({8'h00, op}), PC_VALUE);
      chk("push_pc", {8'h12, op}, PUSH_PC);
      chk("call_stack", m[1] ? 16'h03fc : 16'h03fe, NEXT_STACK_POINTER);
      chk("call_seg", m[1] ? 16'h001f : 16'h0010, {11'h000, PUSH_VALID, PUSH_SEGMENT_EN, SEGMENT_LOAD,
        FAR_RETURN_REQUIRED, PUSH_SEGMENT & m[1]});
    end
    CALL_OPERAND = 8'h4b;
    VECTORED_SHORT_CALL = 1'b1;
    repeat (3) @(negedge CLK);
    chk("odd_operand", 16'h0000, {14'h0000, BUSY, PROG_REQ});
    CALL_OPERAND = 8'h6a;
    repeat (2) @(negedge CLK);
    chk("high_operand", 16'h0000, {14'h0000, BUSY, PROG_REQ});
    VECTORED_SHORT_CALL = 1'b0;
    $display("done t_vcall");
  endtask
  task automatic t_area_short_call;
    for (int k = 0; k < 2; k++) begin
      AREA_FIELD = k ? 11'h7ff : 11'h000;
      NEXT_PC = 16'h2002;
      AREA_SHORT_CALL = 1'b1;
      issue;
      chk("area_pc", k ? 16'h17ff : 16'h1000, PC_VALUE);
      chk("area_push", 16'h2002, PUSH_PC);
      chk("area_stack", 16'h03fe, NEXT_STACK_POINTER);
      chk("area_seg", 16'h0002, {14'h0000, PUSH_VALID, SEGMENT_LOAD});
    end
    $display("done t_area_short_call");
  endtask
  // Entry: address, region small, region full, flags pointer/short bit/window
  task automatic t_data;
    logic [27:0] et [17] = '{28'h0000000, 28'h00ff000, 28'h0100110, 28'h01ff110, 28'h0200224, 28'h023f224,
      28'h0240220, 28'h02c0222, 28'h02ff222, 28'h0300330, 28'h05ff330, 28'h0600430, 28'h09ff430,
      28'h0a00440, 28'h0fff440, 28'h1000441, 28'hffff441};
    for (int i = 0; i < 34; i++) begin
      @(negedge CLK);
      DATA_ADDR = et[i / 2][27:12];
      SMALL_RAM_VARIANT = i[0];
      #1;
      chk("region", {13'h0000, i[0] ? et[i / 2][10:8] : et[i / 2][6:4]}, {13'h0000, DATA_REGION});
      chk("flags", {13'h0000, et[i / 2][2:0]}, {13'h0000, DATA_POINTER_SET, DATA_SHORT_BIT, DATA_ROM_WINDOW});
    end
    $display("done t_data");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short well after the tests should end
  initial begin
    #50000;
    n_fail++;
    $display("ERROR watchdog expected finish seen hang");
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge CLK);
    SRST = 1'b0;
    t_vectors;
    t_vcall;
    t_area_short_call;
    t_data;
    print_verdict;
  end
endmodule
